// [core/rtc_irq_pkg.sv]
// Purpose: Shared constants for the RTC interrupt output and alarm date block
// Assumes: APB with 32-bit data, 40 MHz clock
// Notes: Register constants are word indexes; byte address is four times the index

// =====================================================================
// Package
// =====================================================================
package rtc_irq_pkg;
    // Register word indexes; each register owns one aligned 32-bit word
    localparam logic [19:0] ADDR_INT_CTRL = 20'hF_FFF6;   // Interrupt control
    localparam logic [19:0] ADDR_ALARM_DATE = 20'hF_FFF5; // Alarm date
    localparam logic [19:0] ADDR_FLAGS = 20'hF_FFF0;      // Flags, read clears

    // Interrupt control field positions
    localparam int WIE_POS = 7;
    localparam int AIE_POS = 6;
    localparam int PFE_POS = 5;
    localparam int HL_POS = 3;
    localparam int PL_POS = 2;
    // Writable bits of interrupt control
    localparam logic [7:0] INT_CTRL_MASK = 8'hEC;

    // Alarm date field positions
    localparam int DATE_MASK_POS = 7;
    localparam logic [7:0] ALARM_DATE_MASK = 8'hBF;

    // Flags field positions
    localparam int WDF_POS = 7;
    localparam int AF_POS = 6;
    localparam int PF_POS = 5;

    // Reset values
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    localparam logic [7:0] ALARM_DATE_RESET = 8'h00;

    // Pulse length
    localparam int CLK_HZ = 40_000_000;
    localparam int PULSE_MS = 200;
    localparam int PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_MS;
    localparam int PCNT_W = 24;
endpackage : rtc_irq_pkg

// [core/irq_pin_driver.sv]
// Purpose: Drives the interrupt pin with level or timed pulse behaviour
// Assumes: Events are one-cycle pulses on clk
// Notes: Pulse length is a parameter so simulation can shorten it

`timescale 1ns/10ps

// =====================================================================
// Pin driver
// =====================================================================
module irq_pin_driver
    import rtc_irq_pkg::*;
#(
    parameter logic [PCNT_W-1:0] PULSE_LEN = PCNT_W'(PULSE_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic event_any,
    input wire logic level_hold,
    input wire logic pulse_mode,
    input wire logic active_high,
    // Pin
    output logic int_o,
    output logic int_oe
);
    logic [PCNT_W-1:0] cnt_q;   // Pulse cycles remaining
    logic active;               // Pin asserted

    // Pulse counter restarts on each event
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else if (event_any) begin
            cnt_q <= PULSE_LEN;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - PCNT_W'(1);
        end
    end

    // Pulse mode uses the counter, level mode the held state
    assign active = pulse_mode ? (cnt_q != '0) : level_hold;

    // Active high drives both levels; otherwise open drain low
    assign int_o = active_high ? active : 1'b0;
    assign int_oe = active_high ? 1'b1 : active;

    AST_PULSE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (pulse_mode && event_any) |=> active)
        else $error("Pulse not started");
endmodule : irq_pin_driver

// [core/rtc_irq_ctrl.sv]
// Purpose: Interrupt flags, enables, pin control and alarm date register
// Assumes: APB slave, sources give one-cycle event pulses on clk
// Notes: Flags read clears; set wins over clear
//
// How it works
// - Watchdog timeout sets flag, enabled drives pin
// - Alarm match sets flag, enabled drives pin
// - Power fail sets flag, enabled drives pin
// - Polarity bit: active high or open drain
// - Pulse mode holds pin about 200 ms
// - Level mode holds pin until flags read
// - Reserved control bits read as zero
// - Date register: mask, zero, tens, units
//
// Our own choice: register access over APB.

`timescale 1ns/10ps

// =====================================================================
// Top module
// =====================================================================
module rtc_irq_ctrl
    import rtc_irq_pkg::*;
#(
    parameter logic [PCNT_W-1:0] PULSE_LEN = PCNT_W'(PULSE_CYCLES)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [21:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources
    input wire logic wdog_timeout,
    input wire logic alarm_time_match,
    input wire logic power_fail_event,
    input wire logic [7:0] cur_date,
    // Alarm date comparison result
    output logic date_match,
    // Interrupt pin
    output logic int_o,
    output logic int_oe
);
    // =================================================================
    // Registers
    // =================================================================
    logic [7:0] int_ctrl_q;     // Enables and pin mode
    logic [7:0] alarm_date_q;   // Mask, tens and units of date
    logic watchdog_flag_q;
    logic alarm_flag_q;
    logic power_fail_flag_q;
    logic level_q;              // Level mode pin hold
    logic [31:0] prdata_q;
    logic wr_en;
    logic rd_en;
    logic flags_rd;
    logic mapped;
    logic ev_any;
    logic [7:0] flags_v;
    logic [7:0] flags_clr;      // Flag bits reported by the read now ending

    // Byte address of a register word from its index
    function automatic logic [21:0] word_addr(input logic [19:0] idx);
        return {idx, 2'b00};
    endfunction : word_addr

    // APB access strobes, zero wait states
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign flags_rd = rd_en && (paddr == word_addr(ADDR_FLAGS));
    // Only flags the host has actually seen are cleared, so a late event survives
    assign flags_clr = flags_rd ? prdata_q[7:0] : 8'h00;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_q;

    // Address map check
    always_comb begin
        if (paddr == word_addr(ADDR_INT_CTRL)) begin
            mapped = 1'b1;
        end else if (paddr == word_addr(ADDR_ALARM_DATE)) begin
            mapped = 1'b1;
        end else if (paddr == word_addr(ADDR_FLAGS)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Control register write, reserved bits forced to zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            int_ctrl_q <= INT_CTRL_RESET;
        end else if (wr_en && paddr == word_addr(ADDR_INT_CTRL)) begin
            int_ctrl_q <= pwdata[7:0] & INT_CTRL_MASK;
        end
    end

    // Alarm date write, bit 6 kept at zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alarm_date_q <= ALARM_DATE_RESET;
        end else if (wr_en && paddr == word_addr(ADDR_ALARM_DATE)) begin
            alarm_date_q <= pwdata[7:0] & ALARM_DATE_MASK;
        end
    end

    // Date comparison, masked date always matches
    assign date_match = alarm_date_q[DATE_MASK_POS] ||
        (cur_date[5:0] == alarm_date_q[5:0]);

    // Sticky flags; event in a read cycle wins over the clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_flag_q <= 1'b0;
            alarm_flag_q <= 1'b0;
            power_fail_flag_q <= 1'b0;
        end else begin
            watchdog_flag_q <= wdog_timeout ||
                (watchdog_flag_q && !flags_clr[WDF_POS]);
            alarm_flag_q <= alarm_time_match ||
                (alarm_flag_q && !flags_clr[AF_POS]);
            power_fail_flag_q <= power_fail_event ||
                (power_fail_flag_q && !flags_clr[PF_POS]);
        end
    end

    // Enabled events combine onto the single pin
    assign ev_any = (wdog_timeout && int_ctrl_q[WIE_POS]) ||
        (alarm_time_match && int_ctrl_q[AIE_POS]) ||
        (power_fail_event && int_ctrl_q[PFE_POS]);

    // Level hold: set by event, released by flags read; set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= 1'b0;
        end else begin
            level_q <= ev_any || (level_q && !flags_rd);
        end
    end

    // Read data register
    always_comb begin
        flags_v = 8'h00;
        flags_v[WDF_POS] = watchdog_flag_q;
        flags_v[AF_POS] = alarm_flag_q;
        flags_v[PF_POS] = power_fail_flag_q;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == word_addr(ADDR_INT_CTRL)) begin
                prdata_q <= {24'h00_0000, int_ctrl_q & INT_CTRL_MASK};
            end else if (paddr == word_addr(ADDR_ALARM_DATE)) begin
                prdata_q <= {24'h00_0000, alarm_date_q};
            end else if (paddr == word_addr(ADDR_FLAGS) && mapped) begin
                prdata_q <= {24'h00_0000, flags_v};
            end else begin
                prdata_q <= 32'h0000_0000; // Unmapped reads zero
            end
        end
    end

    // Pin driver
    irq_pin_driver #(
        .PULSE_LEN(PULSE_LEN)
    ) u_pin (
        .clk(clk),
        .rst_b(rst_b),
        .event_any(ev_any),
        .level_hold(level_q),
        .pulse_mode(int_ctrl_q[PL_POS]),
        .active_high(int_ctrl_q[HL_POS]),
        .int_o(int_o),
        .int_oe(int_oe)
    );

    // =================================================================
    // Assertions
    // =================================================================
    AST_WDF_SET: assert property (@(posedge clk) disable iff (!rst_b)
        wdog_timeout |=> watchdog_flag_q)
        else $error("Watchdog flag not set");
    AST_AF_SET: assert property (@(posedge clk) disable iff (!rst_b)
        alarm_time_match |=> alarm_flag_q)
        else $error("Alarm flag not set");
    AST_PF_SET: assert property (@(posedge clk) disable iff (!rst_b)
        power_fail_event |=> power_fail_flag_q)
        else $error("Power fail flag not set");
    AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
        (int_ctrl_q[7:5] == 3'b000 && !level_q && !int_ctrl_q[PL_POS]) |=> !level_q)
        else $error("Pin asserted with sources disabled");
    AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (!rst_b)
        !int_ctrl_q[HL_POS] |-> (int_o == 1'b0))
        else $error("Open drain drove high");
    AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (!int_ctrl_q[PL_POS] && int_ctrl_q[HL_POS] && level_q && !flags_rd &&
        !wr_en) |=> int_o)
        else $error("Level released without read");
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        (int_ctrl_q & ~INT_CTRL_MASK) == 8'h00)
        else $error("Reserved control bit set");
    AST_DATE_B6: assert property (@(posedge clk) disable iff (!rst_b)
        alarm_date_q[6] == 1'b0)
        else $error("Alarm date bit 6 set");
    AST_DATE_MASK: assert property (@(posedge clk) disable iff (!rst_b)
        alarm_date_q[DATE_MASK_POS] |-> date_match)
        else $error("Masked date failed match");
endmodule : rtc_irq_ctrl

// [verif/irq_host_model.sv]
// Purpose: Host end of the interrupt pin, resolves the wire level
// Assumes: The board has a pull-up on the pin
// Notes: Flags reads for the host are issued by the bench
`timescale 1ns/10ps
// =====================================================================
// Host pin model
// =====================================================================
module irq_host_model (
    // Pin from the device
    input wire logic int_o,
    input wire logic int_oe,
    // Polarity the host expects
    input wire logic active_high,
    // Resolved view
    output logic pin_level,
    output logic irq_seen
);
    // Pull-up wins while the device releases the pin
    assign pin_level = int_oe ? int_o : 1'b1;
    // Asserted state follows the chosen polarity
    assign irq_seen = active_high ? pin_level : !pin_level;
endmodule : irq_host_model

// [verif/rtc_irq_ctrl_tb_top.sv]
// Purpose: Self-checking bench for the interrupt and alarm date block
// Assumes: APB slave answers when pready is high; pulse shortened
// Notes: Expected read data is queued and checked by a monitor process
`timescale 1ns/10ps
// =====================================================================
// Bench top
// =====================================================================
module rtc_irq_ctrl_tb_top;
    import rtc_irq_pkg::*;
    localparam logic [PCNT_W-1:0] PLEN = 24'h00_0014; // Short pulse
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [21:0] paddr = 22'h00_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:5] src = 3'h0; // Event sources, by flag bit
    logic [7:0] cur_date = 8'h00;
    logic hl = 1'b1; // Polarity seen by host
    logic pready, pslverr, date_match, int_o, int_oe, pin_level, irq_seen;
    logic [31:0] prdata;
    logic [7:0] d;
    logic [31:0] expq[$]; // Expected read data
    int n_errors = 0;
    int checks_done = 0;
    rtc_irq_ctrl #(.PULSE_LEN(PLEN)) rtc_irq_ctrl_inst (.clk(clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdog_timeout(src[7]),
        .alarm_time_match(src[6]), .power_fail_event(src[5]), .cur_date(cur_date),
        .date_match(date_match), .int_o(int_o), .int_oe(int_oe));
    irq_host_model irq_host_model_inst (.int_o(int_o), .int_oe(int_oe), .active_high(hl),
        .pin_level(pin_level), .irq_seen(irq_seen));
    // Clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        checks_done++;
        if (got !== ex) begin
            $display("Error %s expected %h seen %h", nm, ex, got);
            n_errors++;
        end
    endtask : chk
    task automatic final_report();
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    // One APB transfer; reads queue their expected byte
    task automatic apb(input logic wr, input logic [19:0] a, input logic [7:0] wd,
                       input logic [7:0] ex);
        if (!wr) expq.push_back({24'h00_0000, ex});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {a, 2'b00}; // Word index to byte address
        pwdata <= {24'h00_0000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One-cycle event on source b
    task automatic fire(input int b);
        @(posedge clk);
        src[b] <= 1'b1;
        @(posedge clk);
        src[b] <= 1'b0;
    endtask : fire
    task automatic pin(input logic ex);
        #1;
        chk("irq pin", {31'h0, ex}, {31'h0, irq_seen});
    endtask : pin
    // Monitor: read data against oldest note
    always @(posedge clk) begin
        if (psel && penable && pready) begin
            chk("pslverr", 32'h0, {31'h0, pslverr});
        end
        if (psel && penable && pready && !pwrite) begin
            if (expq.size() == 0) chk("read queue", 32'h0000_0001, 32'h0000_0000);
            else chk("prdata", expq.pop_front(), prdata);
        end
    end
    // Watchdog
    initial begin
        #200000;
        $display("Error watchdog expected done seen timeout");
        n_errors++;
        final_report();
    end
    // =================================================================
    // Tests
    // =================================================================
    initial begin
        void'($urandom(46));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, ADDR_INT_CTRL, 8'h00, 8'h00);
        apb(0, ADDR_ALARM_DATE, 8'h00, 8'h00);
        apb(0, 20'h0_0100, 8'h00, 8'h00);
        apb(1, ADDR_INT_CTRL, 8'hFF, 8'h00);
        apb(0, ADDR_INT_CTRL, 8'h00, 8'hEC);
        d = 8'($urandom());
        apb(1, ADDR_ALARM_DATE, d, 8'h00);
        apb(0, ADDR_ALARM_DATE, 8'h00, d & 8'hBF);
        $display("Test registers done");
        for (int b = 5; b <= 7; b++) begin
            apb(1, ADDR_INT_CTRL, 8'h08, 8'h00);
            fire(b);
            pin(1'b0);
            apb(0, ADDR_FLAGS, 8'h00, 8'(1 << b));
            apb(0, ADDR_FLAGS, 8'h00, 8'h00);
            apb(1, ADDR_INT_CTRL, 8'(1 << b) | 8'h08, 8'h00);
            fire(b);
            pin(1'b1);
            repeat (int'(PLEN) + 5) @(posedge clk);
            pin(1'b1);
            apb(0, ADDR_FLAGS, 8'h00, 8'(1 << b));
            pin(1'b0);
        end
        $display("Test sources done");
        hl = 1'b0;
        apb(1, ADDR_INT_CTRL, 8'h40, 8'h00);
        fire(6);
        pin(1'b1);
        chk("pin level", 32'h0, {31'h0, pin_level});
        apb(0, ADDR_FLAGS, 8'h00, 8'h40);
        pin(1'b0);
        chk("pin enable", 32'h0, {31'h0, int_oe});
        $display("Test open drain done");
        hl = 1'b1;
        apb(1, ADDR_INT_CTRL, 8'h2C, 8'h00);
        fire(5);
        pin(1'b1);
        repeat (int'(PLEN) - 3) @(posedge clk);
        pin(1'b1);
        repeat (4) @(posedge clk);
        pin(1'b0);
        apb(0, ADDR_FLAGS, 8'h00, 8'h20);
        $display("Test pulse done");
        d = 8'($urandom()) & 8'h3F;
        apb(1, ADDR_ALARM_DATE, d | 8'h80, 8'h00);
        cur_date <= ~d;
        @(posedge clk);
        #1 chk("date match", 32'h1, {31'h0, date_match});
        apb(1, ADDR_ALARM_DATE, d, 8'h00);
        #1 chk("date match", 32'h0, {31'h0, date_match});
        @(posedge clk);
        cur_date <= {~d[7:6], d[5:0]};
        @(posedge clk);
        #1 chk("date match", 32'h1, {31'h0, date_match});
        $display("Test date done");
        final_report();
    end
endmodule : rtc_irq_ctrl_tb_top
